// File: common/rsrl_consts.vh
// constants for the rom shadow and ready logic block
`ifndef RSRL_CONSTS_VH
`define RSRL_CONSTS_VH

// -------------------------------------------------------------
// bus status encodings (active-low status, as seen on the pins)
// -------------------------------------------------------------
`define RSRL_ST_MEM_READ   3'h5
`define RSRL_ST_IDLE       3'h7

// -------------------------------------------------------------
// address map
// -------------------------------------------------------------
`define RSRL_ADDR_W        20
`define RSRL_TOP_SEG       4'hf
`define RSRL_SHADOW_BASE   24'h0f0000
`define RSRL_SHADOW_SPAN   24'h010000
`define RSRL_DRAM_MIN_KB   12'h400

// -------------------------------------------------------------
// timing counts in bus t-cycles
// -------------------------------------------------------------
`define RSRL_ROM_WORD_FAST 4'h4
`define RSRL_ROM_WORD_SLOW 4'h6
`define RSRL_DRAM_FAST     4'h4
`define RSRL_DRAM_SLOW     4'h5
`define RSRL_BYTE_BUS_T    4'h8
`define RSRL_CNT_W         4

// -------------------------------------------------------------
// configuration register (axi4-lite)
// -------------------------------------------------------------
`define RSRL_OFS_CFG       4'h0
`define RSRL_OFS_STAT      4'h4
`define RSRL_CFG_ROM_SLOW  0
`define RSRL_CFG_DRAM_SLOW 1
`define RSRL_CFG_SHADOW_EN 2
`define RSRL_CFG_DRAM_KB_L 4
`define RSRL_CFG_DRAM_KB_H 15
`define RSRL_CFG_RESET     32'h00000000
`define RSRL_CFG_MASK      32'h0000fff7
`define RSRL_RESP_OKAY     2'h0
`define RSRL_RESP_SLVERR   2'h2

`endif

// File: core/rsrl_cycle_timer.v
// wait-state timer that releases ready after a loaded count of t-cycles
`timescale 1ns/1ps
`default_nettype none
`include "rsrl_consts.vh"

module rsrl_cycle_timer (
   input  wire                   mclk_i,
   input  wire                   reset_i,
   input  wire                   start_i,
   input  wire [`RSRL_CNT_W-1:0] count_i,
   output wire                   busy_o,
   output wire                   done_o
);

   reg [`RSRL_CNT_W-1:0] left_ff;
   reg [`RSRL_CNT_W-1:0] nxt_left;

   // ----------------------------------------------------------
   // countdown
   // ----------------------------------------------------------
   // load count-1 so the cycle ends on its last t-state
   always @* begin
      nxt_left = left_ff;
      if (start_i) begin
         nxt_left = count_i - 4'h1;
      end else if (left_ff != 4'h0) begin
         nxt_left = left_ff - 4'h1;
      end
   end

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         left_ff <= 4'h0;
      end else begin
         left_ff <= nxt_left;
      end
   end

   assign busy_o = (left_ff != 4'h0);
   // done on the last t-state of the cycle
   assign done_o = (left_ff == 4'h1);

endmodule // rsrl_cycle_timer

`default_nettype wire

// File: core/rsrl_top.v
// rom placement, shadow redirect and ready generation for the host bus
`timescale 1ns/1ps
`default_nettype none
`include "rsrl_consts.vh"

// Operation
// - The rom bus select input reads high when left open.
// - A high rom bus select means the rom sits on the 16-bit word bus.
// - A word-bus rom read lasts 4 or 6 processor t-cycles by setting.
// - A low rom bus select means the rom sits on the 8-bit byte bus.
// - A byte-bus rom word read lasts 8 expansion t-cycles.
// - With shadowing on, top-range accesses go to shadow dram.
// - A shadow dram read lasts 4 or 5 processor t-cycles by setting.
// - Shadowing is allowed only with at least 1 Mbyte of dram.
// - Active shadowing reserves 64 Kbytes of dram for the copy.
// - The emulation vector input makes the rom answer emulation cycles.
// - The block drives both async and sync ready of the host bus.
// - In some cycles both readies follow the companion ready input.
// - Async ready changes on falling edges of the sampling clock.
// - The block drives an active-low rom chip enable.
// - Word-bus accesses pull the open-drain bus location line low.
// - Even word accesses on the byte bus run even byte then odd byte.
module rsrl_top (
   input  wire        mclk_i,
   input  wire        reset_i,
   // host bus
   input  wire [19:0] system_address_bus_i,
   input  wire [2:0]  bus_status_n_i,
   input  wire        byte_high_en_n_i,
   input  wire        rom_bus_select_i,
   input  wire        rom_bus_select_oe_i,
   input  wire        emulation_vector_select_i,
   input  wire        companion_ready_i,
   input  wire        ready_sample_clock_i,
   input  wire        expansion_tick_i,
   output wire        async_ready_out_o,
   output wire        sync_ready_out_o,
   output wire        rom_ce_n_o,
   output wire        shadow_dram_sel_o,
   output wire [23:0] shadow_dram_addr_o,
   output wire        byte_addr0_o,
   output wire        bus_location_line_o,
   output wire        bus_location_line_oe_n_o,
   // axi4-lite slave
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready
);

   // ----------------------------------------------------------
   // states
   // ----------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_WORD  = 3'h1;
   localparam [2:0] ST_BYTE0 = 3'h2;
   localparam [2:0] ST_BYTE1 = 3'h3;
   localparam [2:0] ST_DONE  = 3'h4;

   reg [31:0] cfg_ff;
   reg        aw_ok_ff;
   reg        w_ok_ff;
   reg [3:0]  aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0]  w_strb_ff;
   reg        bvalid_ff;
   reg [1:0]  bresp_ff;
   reg        rvalid_ff;
   reg [1:0]  rresp_ff;
   reg [31:0] rdata_ff;
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg        rom_ce_ff;
   reg        shadow_ff;
   reg        loc_ad_ff;
   reg        a0_ff;
   reg        sync_ready_out_ff;
   reg        async_ready_out_ff;
   reg        done_sync_ff;
   reg [3:0]  ticks_ff;
   reg [23:0] sh_addr_ff;
   reg [3:0]  load_cnt;
   reg        tmr_start;

   wire tmr_busy;
   wire tmr_done;

   // ----------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------
   function top_range;
      input [19:0] a;
      begin
         top_range = (a[19:16] == `RSRL_TOP_SEG);
      end
   endfunction

   wire mem_read   = (bus_status_n_i == `RSRL_ST_MEM_READ);
   wire cycle_new  = mem_read & (state_ff == ST_IDLE);
   wire word_rom   = rom_bus_select_oe_i ? rom_bus_select_i : 1'b1;
   // shadow needs 1 Mbyte or more
   wire dram_ok    = cfg_ff[`RSRL_CFG_DRAM_KB_H:`RSRL_CFG_DRAM_KB_L]
                     >= `RSRL_DRAM_MIN_KB;
   wire shadow_on  = cfg_ff[`RSRL_CFG_SHADOW_EN] & dram_ok;
   wire rom_hit    = emulation_vector_select_i |
                     (top_range(system_address_bus_i) & ~shadow_on);
   wire shadow_hit = top_range(system_address_bus_i) & shadow_on &
                     ~emulation_vector_select_i;
   // even word access on byte bus
   wire dbl_cycle  = ~system_address_bus_i[0] & ~byte_high_en_n_i;

   // ----------------------------------------------------------
   // axi4-lite write path
   // ----------------------------------------------------------
   assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
   assign s_axi_wready  = ~w_ok_ff & ~bvalid_ff;

   // address and data may land in either order
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_ok_ff   <= 1'b0;
         w_ok_ff    <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff  <= 32'h00000000;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RSRL_RESP_OKAY;
         cfg_ff     <= `RSRL_CFG_RESET;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_ok_ff   <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_ok_ff   <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (aw_ok_ff & w_ok_ff) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            bvalid_ff <= 1'b1;
            if (aw_addr_ff == `RSRL_OFS_CFG) begin
               bresp_ff <= `RSRL_RESP_OKAY;
               cfg_ff   <= ((w_strb_ff[0] ? w_data_ff[7:0]
                                          : cfg_ff[7:0])
                           | {24'h000000, 8'h00})
                           & `RSRL_CFG_MASK
                           | ({(w_strb_ff[1] ? w_data_ff[15:8]
                                             : cfg_ff[15:8]), 8'h00}
                              & `RSRL_CFG_MASK);
            end else if (aw_addr_ff == `RSRL_OFS_STAT) begin
               bresp_ff <= `RSRL_RESP_OKAY; // status is read-only
            end else begin
               bresp_ff <= `RSRL_RESP_SLVERR;
            end
         end else if (bvalid_ff & s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // ----------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------
   assign s_axi_arready = ~rvalid_ff;

   // status shows live cycle state and effective shadow enable
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= `RSRL_RESP_OKAY;
         rdata_ff  <= 32'h00000000;
      end else if (s_axi_arvalid & s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= `RSRL_RESP_OKAY;
         if (s_axi_araddr == `RSRL_OFS_CFG) begin
            rdata_ff <= cfg_ff;
         end else if (s_axi_araddr == `RSRL_OFS_STAT) begin
            rdata_ff <= {24'h000000, state_ff, shadow_ff, ~rom_ce_ff,
                         word_rom, dram_ok, shadow_on};
         end else begin
            rdata_ff <= 32'h00000000;
            rresp_ff <= `RSRL_RESP_SLVERR;
         end
      end else if (rvalid_ff & s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp  = rresp_ff;
   assign s_axi_rdata  = rdata_ff;

   // ----------------------------------------------------------
   // cycle length selection
   // ----------------------------------------------------------
   always @* begin
      load_cnt  = 4'h1;
      tmr_start = 1'b0;
      if (cycle_new & shadow_hit) begin
         tmr_start = 1'b1;
         load_cnt  = cfg_ff[`RSRL_CFG_DRAM_SLOW] ? `RSRL_DRAM_SLOW
                                                  : `RSRL_DRAM_FAST;
      end else if (cycle_new & rom_hit & word_rom) begin
         tmr_start = 1'b1;
         load_cnt  = cfg_ff[`RSRL_CFG_ROM_SLOW] ? `RSRL_ROM_WORD_SLOW
                                                 : `RSRL_ROM_WORD_FAST;
      end
   end

   rsrl_cycle_timer u_timer (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .start_i (tmr_start),
      .count_i (load_cnt),
      .busy_o  (tmr_busy),
      .done_o  (tmr_done)
   );

   // ----------------------------------------------------------
   // cycle sequencer
   // ----------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (cycle_new & (shadow_hit | (rom_hit & word_rom))) begin
               nxt_state = ST_WORD;
            end else if (cycle_new & rom_hit) begin
               nxt_state = ST_BYTE0;
            end
         end
         ST_WORD: begin
            if (tmr_done | ~tmr_busy) begin
               nxt_state = ST_DONE;
            end
         end
         ST_BYTE0: begin
            if (ticks_ff == 4'h0) begin
               nxt_state = ST_BYTE1;
            end
         end
         ST_BYTE1: begin
            if (ticks_ff == 4'h0) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            if (bus_status_n_i == `RSRL_ST_IDLE) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // byte-bus time: half of the word time per byte when split
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ticks_ff <= 4'h0;
      end else if (state_ff == ST_IDLE) begin
         ticks_ff <= dbl_cycle ? (`RSRL_BYTE_BUS_T >> 1)
                               : `RSRL_BYTE_BUS_T;
      end else if (state_ff == ST_BYTE0 & ticks_ff == 4'h0) begin
         ticks_ff <= dbl_cycle ? (`RSRL_BYTE_BUS_T >> 1) : 4'h0;
      end else if (expansion_tick_i & ticks_ff != 4'h0) begin
         ticks_ff <= ticks_ff - 4'h1;
      end
   end

   // ----------------------------------------------------------
   // output registers
   // ----------------------------------------------------------
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff     <= ST_IDLE;
         rom_ce_ff    <= 1'b0;
         shadow_ff    <= 1'b0;
         loc_ad_ff    <= 1'b0;
         a0_ff        <= 1'b0;
         sync_ready_out_ff      <= 1'b1;
         done_sync_ff <= 1'b0;
         sh_addr_ff   <= 24'h000000;
      end else begin
         state_ff <= nxt_state;
         if (cycle_new) begin
            rom_ce_ff  <= rom_hit;
            shadow_ff  <= shadow_hit;
            loc_ad_ff  <= shadow_hit | (rom_hit & word_rom);
            sh_addr_ff <= `RSRL_SHADOW_BASE +
                          {8'h00, system_address_bus_i[15:0]};
            a0_ff      <= system_address_bus_i[0];
         end else if (nxt_state == ST_IDLE) begin
            rom_ce_ff <= 1'b0;
            shadow_ff <= 1'b0;
            loc_ad_ff <= 1'b0;
         end
         // odd byte in second half
         // only a split word moves on to the odd byte
         if (state_ff == ST_BYTE0 & nxt_state == ST_BYTE1 & dbl_cycle) begin
            a0_ff <= 1'b1;
         end
         // sync ready low while a timed cycle runs
         sync_ready_out_ff <= ~((nxt_state == ST_WORD) | (nxt_state == ST_BYTE0) |
                      (nxt_state == ST_BYTE1));
         done_sync_ff <= (nxt_state == ST_DONE) | (nxt_state == ST_IDLE);
      end
   end

   // ----------------------------------------------------------
   // async ready on the sampling clock
   // ----------------------------------------------------------
   // falling edge of sampling clock
   always @(negedge ready_sample_clock_i or posedge reset_i) begin
      if (reset_i) begin
         async_ready_out_ff <= 1'b1;
      end else begin
         async_ready_out_ff <= done_sync_ff & companion_ready_i;
      end
   end

   // sync ready also gated by companion ready outside word-bus and shadow cycles
   assign sync_ready_out_o         = sync_ready_out_ff &
                                     (companion_ready_i | loc_ad_ff);
   assign async_ready_out_o        = async_ready_out_ff;
   assign rom_ce_n_o               = ~rom_ce_ff;
   assign shadow_dram_sel_o        = shadow_ff;
   assign shadow_dram_addr_o       = sh_addr_ff;
   assign byte_addr0_o             = a0_ff;
   assign bus_location_line_o      = 1'b0;
   assign bus_location_line_oe_n_o = ~loc_ad_ff;

endmodule // rsrl_top

`default_nettype wire

// File: tb/rsrl_checker.sv
// port assertions for the rom shadow and ready block
`timescale 1ns/1ps
`default_nettype none
module rsrl_checker (
   input wire logic        mclk_i,
   input wire logic        reset_i,
   input wire logic [19:0] system_address_bus_i,
   input wire logic [2:0]  bus_status_n_i,
   input wire logic        rom_bus_select_i,
   input wire logic        rom_bus_select_oe_i,
   input wire logic        companion_ready_i,
   input wire logic        ready_sample_clock_i,
   input wire logic        async_ready_out_o,
   input wire logic        sync_ready_out_o,
   input wire logic        rom_ce_n_o,
   input wire logic        shadow_dram_sel_o,
   input wire logic [23:0] shadow_dram_addr_o,
   input wire logic        byte_addr0_o,
   input wire logic        bus_location_line_o,
   input wire logic        bus_location_line_oe_n_o
);
   // an undriven select pin counts as the word bus
   wire word_bus = rom_bus_select_i | ~rom_bus_select_oe_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   property p_ce_top;
      $fell(rom_ce_n_o) |-> $past(bus_status_n_i) == 3'h5 &&
         $past(system_address_bus_i[19:16]) == 4'hf;
   endproperty
   a_ce_top: assert property (p_ce_top)
      else $error("rom enable off top read");
   property p_sh_addr;
      shadow_dram_sel_o |-> shadow_dram_addr_o ==
         {8'h0f, $past(system_address_bus_i[15:0])};
   endproperty
   a_sh_addr: assert property (p_sh_addr)
      else $error("shadow address wrong");
   property p_excl;
      shadow_dram_sel_o |-> rom_ce_n_o;
   endproperty
   a_excl: assert property (p_excl)
      else $error("rom and shadow both on");
   property p_loc;
      shadow_dram_sel_o || (!rom_ce_n_o && word_bus) |->
         !bus_location_line_oe_n_o && !bus_location_line_o;
   endproperty
   a_loc: assert property (p_loc)
      else $error("location line not low");
   property p_byte;
      !rom_ce_n_o && !word_bus |-> bus_location_line_oe_n_o;
   endproperty
   a_byte: assert property (p_byte)
      else $error("byte rom pulled line");
   property p_sync_ready_out;
      $fell(rom_ce_n_o) || $rose(shadow_dram_sel_o) |-> !sync_ready_out_o;
   endproperty
   a_sync_ready_out: assert property (p_sync_ready_out)
      else $error("sync ready not held");
   property p_min;
      $fell(sync_ready_out_o) |-> !sync_ready_out_o [*3];
   endproperty
   a_min: assert property (p_min)
      else $error("wait too short");
   property p_max;
      $fell(sync_ready_out_o) && !bus_location_line_oe_n_o |->
         ##[1:6] sync_ready_out_o;
   endproperty
   a_max: assert property (p_max)
      else $error("word wait too long");
   property p_split;
      $rose(byte_addr0_o) |-> bus_location_line_oe_n_o && !sync_ready_out_o;
   endproperty
   a_split: assert property (p_split)
      else $error("odd byte outside split");
   property p_async;
      @(negedge ready_sample_clock_i) disable iff (reset_i)
         async_ready_out_o |-> $past(companion_ready_i);
   endproperty
   a_async: assert property (p_async)
      else $error("async ready early");
endmodule // rsrl_checker

bind rsrl_top rsrl_checker chk_u (.*);
`default_nettype wire

// File: tb/rsrl_host_model.sv
// host processor and companion chip model for one memory read
`timescale 1ns/1ps
`default_nettype none
module rsrl_host_model (
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        start_i,
   input  wire logic [19:0] addr_i,
   input  wire logic        bhe_n_i,
   input  wire logic [7:0]  comp_wait_i,
   input  wire logic        sync_ready_out_i,
   output logic      [19:0] addr_o,
   output logic      [2:0]  status_n_o,
   output logic             bhe_n_o,
   output logic             comp_rdy_o
);
   logic [1:0] st_ff;
   logic [7:0] wt_ff;
   // status held until sync ready drops and comes back
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= 2'h0;
         status_n_o <= 3'h7;
         addr_o <= 20'h0;
         bhe_n_o <= 1'b1;
      end else if (st_ff == 2'h0 && start_i) begin
         st_ff <= 2'h1;
         status_n_o <= 3'h5;
         addr_o <= addr_i;
         bhe_n_o <= bhe_n_i;
      end else if (st_ff == 2'h1 && !sync_ready_out_i) begin
         st_ff <= 2'h2;
      end else if (st_ff == 2'h2 && sync_ready_out_i) begin
         st_ff <= 2'h0;
         status_n_o <= 3'h7;
         // released bus shows no stale value
         addr_o <= ~addr_o;
         bhe_n_o <= ~bhe_n_o;
      end
   end
   // companion holds its ready low for a chosen count, slow or prompt
   // companion ready
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         wt_ff <= 8'h0;
         comp_rdy_o <= 1'b1;
      end else if (st_ff == 2'h0 && start_i) begin
         wt_ff <= comp_wait_i;
         comp_rdy_o <= (comp_wait_i == 8'h0);
      end else if (wt_ff != 8'h0) begin
         wt_ff <= wt_ff - 8'h1;
         comp_rdy_o <= (wt_ff == 8'h1);
      end
   end
endmodule // rsrl_host_model
`default_nettype wire

// File: tb/tb_rom_shadow_ready_logic.sv
// self-checking bench for the rom shadow and ready block
`timescale 1ns/1ps
`default_nettype none
`include "rsrl_consts.vh"
module tb_rom_shadow_ready_logic;
   logic mclk_i = 0, reset_i = 1, expansion_tick_i = 0;
   logic rom_bus_select_i = 0, rom_bus_select_oe_i = 0;
   logic emulation_vector_select_i = 0, byte_high_en_n_i;
   logic companion_ready_i, ready_sample_clock_i;
   logic [19:0] system_address_bus_i;
   logic [2:0]  bus_status_n_i;
   logic async_ready_out_o, sync_ready_out_o, rom_ce_n_o;
   logic shadow_dram_sel_o, byte_addr0_o, bus_location_line_o;
   logic bus_location_line_oe_n_o;
   logic [23:0] shadow_dram_addr_o;
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic hst = 0, hb = 1, ce_s, sh_s, oe_s, a0_s, ar_s;
   logic [19:0] ha = 0;
   logic [7:0]  cw = 0;
   logic [23:0] da_s;
   int fail_count = 0, checked = 0, n;
   // -------------------------------------------------------------
   // clocks and instances
   // -------------------------------------------------------------
   always #12.5 mclk_i = ~mclk_i;
   // sampling clock shares the processor clock, as a board may do
   assign ready_sample_clock_i = mclk_i;
   // one expansion t-cycle every two processor cycles
   always @(posedge mclk_i) expansion_tick_i <= ~expansion_tick_i;
   rsrl_top dut_u (.*);
   rsrl_host_model host_u (.mclk_i, .reset_i, .start_i(hst), .addr_i(ha),
      .bhe_n_i(hb), .comp_wait_i(cw), .sync_ready_out_i(sync_ready_out_o),
      .addr_o(system_address_bus_i), .status_n_o(bus_status_n_i),
      .bhe_n_o(byte_high_en_n_i), .comp_rdy_o(companion_ready_i));
   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge mclk_i);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!(s_axi_bvalid && s_axi_bready));
      chk(s_axi_bresp, r);
      s_axi_bready <= 0;
      @(posedge mclk_i);
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!(s_axi_rvalid && s_axi_rready));
      chk(s_axi_rdata & m, d & m);
      chk(s_axi_rresp, r);
      s_axi_rready <= 0;
      @(posedge mclk_i);
   endtask
   // host read; n counts edges from the taking edge to sync ready high
   task automatic rd(input logic [19:0] a, input logic b, input logic [7:0] w);
      hst <= 1;
      ha <= a;
      hb <= b;
      cw <= w;
      @(posedge mclk_i);
      hst <= 0;
      n = 0;
      a0_s = 0;
      do begin
         @(posedge mclk_i);
         #1;
         n++;
         a0_s = a0_s | byte_addr0_o;
         // async ready has seen the busy cycle by the second edge
         if (n == 2) ar_s = async_ready_out_o;
         if (n == 1) {ce_s, sh_s, oe_s, da_s} = {rom_ce_n_o,
            shadow_dram_sel_o, bus_location_line_oe_n_o, shadow_dram_addr_o};
      end while (sync_ready_out_o !== 1'b1 && n < 200);
      repeat (3) @(posedge mclk_i);
   endtask
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_regs;
      axr(4'h0, 32'h0, 32'hffffffff, `RSRL_RESP_OKAY);
      axw(4'h0, 32'hffffffff, `RSRL_RESP_OKAY);
      axr(4'h0, 32'h0000fff7, 32'hffffffff, `RSRL_RESP_OKAY);
      axw(4'h4, 32'h0, `RSRL_RESP_OKAY);
      axw(4'h8, 32'h1, `RSRL_RESP_SLVERR);
      axr(4'h8, 32'h0, 32'h0, `RSRL_RESP_SLVERR);
      $display("test regs done");
   endtask
   task automatic t_word;
      for (int s = 0; s < 3; s++) begin
         rom_bus_select_oe_i <= (s == 2);
         rom_bus_select_i <= (s == 2);
         axw(4'h0, s[0], `RSRL_RESP_OKAY);
         rd(20'hf0102, 1'b0, 8'h9);
         chk(n, s[0] ? `RSRL_ROM_WORD_SLOW : `RSRL_ROM_WORD_FAST);
         chk({ce_s, sh_s, oe_s}, 3'b000);
         chk(ar_s, 1'b0);
         chk(async_ready_out_o, 1'b0);
      end
      $display("test word done");
   endtask
   task automatic t_shadow;
      for (int s = 0; s < 2; s++) begin
         axw(4'h0, 32'h4004 | (s << 1), `RSRL_RESP_OKAY);
         axr(4'h4, 32'h3, 32'h3, `RSRL_RESP_OKAY);
         rd(20'hf1234, 1'b0, 8'h0);
         chk(n, s ? `RSRL_DRAM_SLOW : `RSRL_DRAM_FAST);
         chk({ce_s, sh_s, oe_s}, 3'b110);
         chk(da_s, 24'h0f1234);
         chk(async_ready_out_o, 1'b1);
      end
      emulation_vector_select_i <= 1;
      rd(20'hf0200, 1'b0, 8'h0);
      chk({ce_s, sh_s}, 2'b00);
      emulation_vector_select_i <= 0;
      axw(4'h0, 32'h3ff4, `RSRL_RESP_OKAY);
      axr(4'h4, 32'h0, 32'h3, `RSRL_RESP_OKAY);
      rd(20'hf1234, 1'b0, 8'h0);
      chk({ce_s, sh_s}, 2'b00);
      $display("test shadow done");
   endtask
   task automatic t_byte;
      rom_bus_select_oe_i <= 1;
      rom_bus_select_i <= 0;
      axw(4'h0, 32'h0, `RSRL_RESP_OKAY);
      rd(20'hf0100, 1'b0, 8'd30);
      chk({ce_s, oe_s, a0_s}, 3'b011);
      // byte timing ends first, so the companion's 30 cycles decide
      chk(n, 30);
      rd(20'hf0100, 1'b1, 8'h0);
      chk({ce_s, oe_s, a0_s}, 3'b010);
      chk(n >= 15 && n <= 24, 1);
      rom_bus_select_oe_i <= 0;
      $display("test byte done");
   endtask
   // -------------------------------------------------------------
   // run control
   // -------------------------------------------------------------
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge mclk_i);
      reset_i <= 0;
      @(posedge mclk_i);
      t_regs();
      t_word();
      t_shadow();
      t_byte();
      conclude();
   end
   // the whole run costs far less than this time budget for a hang
   initial begin
      #(30000 * 25);
      fail_count++;
      conclude();
   end
endmodule // tb_rom_shadow_ready_logic
`default_nettype wire
